// >>> core/crc_top.sv
// clock and reset control: oscillator sequencing, clock tree rates,
// clock gates, core reset generation and a classic Wishbone slave.
// assumes one 40 MHz clock; reset pin and crystal ready are async pins.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "crc_defs.svh"
module crc_top
#(
    parameter int CORE_RST_CYC = `CRC_CORE_RST_CYC,
    parameter logic [`CRC_NUM_GATES-1:0] FULL_MASK = `CRC_FULL_MASK
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic external_reset_pin_low_active_i,
    input wire logic crystal_osc_ready_i,
    input wire logic sleep_i,
    input wire logic wake_exit_i,
    input wire logic wdg_reset_i,
    input wire logic sys_reset_req_i,
    input wire logic lockup_i,
    output logic xtal_high_freq_select_o,
    output logic ring_osc_en_o,
    output logic crystal_osc_en_o,
    output logic hs_from_crystal_o,
    output logic lf_from_crystal_o,
    output logic shutdown_o,
    output logic wakeup_logic_reset_o,
    output logic debug_reset_o,
    output logic core_reset_o,
    output logic [`CRC_NUM_GATES-1:0] gclk_o
);
    localparam logic [`CRC_CNT_W-1:0] RST_LOAD =
        `CRC_CNT_W'(CORE_RST_CYC - 1);

    logic pin_meta_q;
    logic pin_sync_q;
    logic rdy_meta_q;
    logic rdy_sync_q;
    logic por_q;
    logic shutdown_q;
    logic debug_reset_q;
    logic core_reset_q;
    logic [`CRC_CNT_W-1:0] rst_cnt_q;
    logic core_req;
    logic regs_rst;
    logic xsel_q;
    logic [1:0] osc_q;
    logic [`CRC_NUM_SW-1:0] clk_en_q;
    crc_pkg::crc_cause_t cause_q;
    crc_pkg::crc_cause_t cause_set;
    crc_pkg::crc_osc_state_t state_q;
    logic ring_en_q;
    logic xtal_en_q;
    logic from_xtal_q;
    logic half_q;
    logic div_on;
    logic slow_tick;
    logic [`CRC_NUM_GATES-1:0] gate_en;
    logic [`CRC_NUM_GATES-1:0] gate_tick;
    logic ack_q;
    logic [31:0] dat_q;
    logic [31:0] rd_data;
    logic acc;
    logic wr;

    // pins cross into the clock domain through two flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            rdy_meta_q <= 1'b0;
            rdy_sync_q <= 1'b0;
        end
        else
        begin
            pin_meta_q <= external_reset_pin_low_active_i;
            pin_sync_q <= pin_meta_q;
            rdy_meta_q <= crystal_osc_ready_i;
            rdy_sync_q <= rdy_meta_q;
        end
    end

    // pin held low means shutdown and power-on reset everywhere
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            por_q <= 1'b1;
            shutdown_q <= 1'b1;
            debug_reset_q <= 1'b1;
        end
        else
        begin
            por_q <= ~pin_sync_q;
            shutdown_q <= ~pin_sync_q;
            debug_reset_q <= ~pin_sync_q;
        end
    end

    assign core_req = por_q | wake_exit_i
        | wdg_reset_i | sys_reset_req_i | lockup_i;

    // stretched so every core flop sees a clean multi-cycle pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_reset_q <= 1'b1;
            rst_cnt_q <= RST_LOAD;
        end
        else if (core_req)
        begin
            core_reset_q <= 1'b1;
            rst_cnt_q <= RST_LOAD;
        end
        else if (rst_cnt_q != '0)
            rst_cnt_q <= rst_cnt_q - 1'b1;
        else
            core_reset_q <= 1'b0;
    end

    assign regs_rst = rst_i | core_reset_q;

    // event flags keep the cause across core resets; set beats clear
    assign cause_set = '{lockup: lockup_i, sysreq: sys_reset_req_i,
        watchdog_timer_unit: wdg_reset_i, wake: wake_exit_i};

    always_ff @(posedge clk_i)
    begin
        if (rst_i || por_q)
            cause_q <= '0;
        else if (wr && wb_adr_i == `CRC_OFF_CAUSE && wb_sel_i[0])
            cause_q <= (cause_q & ~wb_dat_i[3:0]) | cause_set;
        else
            cause_q <= cause_q | cause_set;
    end

    // Wishbone: ack one cycle after the request, write at the ack edge
    assign acc = wb_cyc_i & wb_stb_i & ack_q;
    assign wr = acc & wb_we_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end
        else
        begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            dat_q <= (wb_cyc_i & wb_stb_i & ~ack_q) ? rd_data : '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (regs_rst)
            xsel_q <= `CRC_XTAL_RST;
        else if (wr && wb_adr_i == `CRC_OFF_XTAL && wb_sel_i[0])
            xsel_q <= wb_dat_i[`CRC_XSEL_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (regs_rst)
            osc_q <= `CRC_OSC_RST;
        else if (wr && wb_adr_i == `CRC_OFF_OSC && wb_sel_i[0])
            osc_q <= wb_dat_i[1:0];
    end

    // byte lanes 0..2 carry the seventeen software gate enables
    always_ff @(posedge clk_i)
    begin
        if (regs_rst)
            clk_en_q <= `CRC_CLKEN_RST;
        else if (wr && wb_adr_i == `CRC_OFF_CLKEN)
        begin
            if (wb_sel_i[0])
                clk_en_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                clk_en_q[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2])
                clk_en_q[16] <= wb_dat_i[16];
        end
    end

    // reserved bits read zero; unmapped addresses answer zero
    always_comb
    begin
        rd_data = '0;
        case (wb_adr_i)
            `CRC_OFF_XTAL: rd_data[`CRC_XSEL_BIT] = xsel_q;
            `CRC_OFF_OSC: rd_data[1:0] = osc_q;
            `CRC_OFF_CLKEN: rd_data[`CRC_NUM_SW-1:0] = clk_en_q;
            `CRC_OFF_STATUS: rd_data[6:0] = {div_on, sleep_i,
                xtal_en_q, ring_en_q, from_xtal_q, state_q};
            `CRC_OFF_CAUSE: rd_data[3:0] = cause_q;
            default: rd_data = '0;
        endcase
    end

    // oscillator sequencing; crystal used only once it reports ready
    always_ff @(posedge clk_i)
    begin
        if (regs_rst)
            state_q <= crc_pkg::CRC_OSC_PRE;
        else
        begin
            case (state_q)
                crc_pkg::CRC_OSC_PRE:
                    if (osc_q[`CRC_OSC_XREQ_BIT])
                        state_q <= crc_pkg::CRC_OSC_START;
                crc_pkg::CRC_OSC_START:
                    if (!osc_q[`CRC_OSC_XREQ_BIT])
                        state_q <= crc_pkg::CRC_OSC_PRE;
                    else if (rdy_sync_q)
                        state_q <= crc_pkg::CRC_OSC_ACTIVE;
                crc_pkg::CRC_OSC_ACTIVE:
                    if (!osc_q[`CRC_OSC_XREQ_BIT])
                        state_q <= crc_pkg::CRC_OSC_PRE;
                    else if (!rdy_sync_q)
                        state_q <= crc_pkg::CRC_OSC_START;
                default:
                    state_q <= crc_pkg::CRC_OSC_PRE;
            endcase
        end
    end

    // oscillator enables follow the state one cycle later
    always_ff @(posedge clk_i)
    begin
        if (regs_rst)
        begin
            ring_en_q <= 1'b1;
            xtal_en_q <= 1'b0;
            from_xtal_q <= 1'b0;
        end
        else
        begin
            ring_en_q <= state_q != crc_pkg::CRC_OSC_ACTIVE;
            xtal_en_q <= state_q != crc_pkg::CRC_OSC_PRE;
            from_xtal_q <= state_q == crc_pkg::CRC_OSC_ACTIVE;
        end
    end

    // half-rate enable for branches 1, 2 and 18, the ones outside FULL_MASK
    assign div_on = xsel_q & from_xtal_q;

    always_ff @(posedge clk_i)
    begin
        if (regs_rst || !div_on)
            half_q <= 1'b0;
        else
            half_q <= ~half_q;
    end

    assign slow_tick = div_on ? half_q : 1'b1;

    always_comb
    begin
        gate_en = '0;
        gate_en[`CRC_NUM_SW-1:0] = clk_en_q;
        gate_en[`CRC_G_CPU] = ~sleep_i;
        gate_en[`CRC_G_RAM] = ~sleep_i | clk_en_q[`CRC_G_SPI]
            | clk_en_q[`CRC_G_RADIO];
    end

    // full-rate branches tick every cycle; the rest may be divided
    assign gate_tick = FULL_MASK | {`CRC_NUM_GATES{slow_tick}};

    generate
        for (genvar g = 0; g < `CRC_NUM_GATES; g++)
        begin : g_gate
            crc_clk_gate u_gate
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .tick_i(gate_tick[g]),
                .en_i(gate_en[g]),
                .gclk_o(gclk_o[g])
            );
        end
    endgenerate

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign xtal_high_freq_select_o = xsel_q;
    assign ring_osc_en_o = ring_en_q;
    assign crystal_osc_en_o = xtal_en_q;
    assign hs_from_crystal_o = from_xtal_q;
    assign lf_from_crystal_o = osc_q[`CRC_OSC_LFX_BIT];
    assign shutdown_o = shutdown_q;
    assign wakeup_logic_reset_o = por_q;
    assign debug_reset_o = debug_reset_q;
    assign core_reset_o = core_reset_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_xsel_write: assert property (
        wr && wb_adr_i == `CRC_OFF_XTAL && wb_sel_i[0] && !core_reset_q
        |=> xsel_q == $past(wb_dat_i[0]))
        else $error("crystal select did not take the write");
    a_lf_select: assert property (
        wr && wb_adr_i == `CRC_OFF_OSC && wb_sel_i[0] && !core_reset_q
        |=> lf_from_crystal_o == $past(wb_dat_i[1]))
        else $error("low-frequency source did not follow write");
    a_ring_startup: assert property (
        xtal_en_q && !from_xtal_q |-> ring_en_q)
        else $error("ring oscillator off during crystal startup");
    a_cpu_full: assert property (
        gate_en[`CRC_G_CPU] && $past(gate_en[`CRC_G_CPU]) && gclk_o[17]
        |=> !gclk_o[17])
        else $error("processor clock not at full rate");
    a_half_branch: assert property (
        div_on && $past(div_on) && slow_tick |=> !slow_tick || !div_on)
        else $error("divided branch ticked twice in a row");
    a_clken_write: assert property (
        wr && wb_adr_i == `CRC_OFF_CLKEN && wb_sel_i == 4'hf
        && !core_reset_q
        |=> clk_en_q == $past(wb_dat_i[16:0]))
        else $error("clock enables did not take the write");
    a_pka_reset: assert property (
        $past(core_reset_q) && !core_reset_q |->
        clk_en_q == `CRC_CLKEN_RST && !clk_en_q[`CRC_G_PKA])
        else $error("clock enables wrong after reset");
    a_cpu_sleep: assert property (
        sleep_i [*3] |-> !gclk_o[`CRC_G_CPU])
        else $error("processor clock runs in sleep");
    a_ram_gate: assert property (
        (!gate_en[`CRC_G_RAM]) [*4] |-> !gclk_o[`CRC_G_RAM])
        else $error("RAM clock runs with its users off");
    a_wake_reset: assert property (
        wake_exit_i |=> core_reset_o [*2])
        else $error("wake exit gave no core reset");
    a_src_reset: assert property (
        wdg_reset_i || sys_reset_req_i || lockup_i |=> core_reset_o)
        else $error("reset source gave no core reset");
    a_pin_shut: assert property (
        !pin_sync_q |=> shutdown_o && wakeup_logic_reset_o ##1 core_reset_o)
        else $error("held pin did not shut down");
    a_dbg_por_only: assert property (
        pin_sync_q && !por_q && (wdg_reset_i || lockup_i)
        |=> !debug_reset_o)
        else $error("debug reset followed a core reset");
    a_start_rc: assert property (
        $fell(core_reset_q) |-> state_q == crc_pkg::CRC_OSC_PRE && ring_en_q)
        else $error("did not start on the ring oscillator");
    a_ring_off: assert property (
        from_xtal_q |-> !ring_en_q)
        else $error("ring oscillator left on with crystal active");

    c_xtal_32: cover property (div_on ##1 div_on);
    c_wdg_cause: cover property (cause_q.watchdog_timer_unit && !core_reset_q);
    c_ram_off: cover property (!gate_en[`CRC_G_RAM] [*4]);
    c_bus_read: cover property (acc && !wb_we_i
        && wb_adr_i == `CRC_OFF_STATUS);
endmodule

// >>> core/crc_defs.svh
// constants of the clock and reset control block: offsets, fields,
// reset values and counts; included by the design files by bare name.
// Operation
// - bit 0 of the crystal register selects 16 MHz (0) or 32 MHz (1).
// - low-frequency clock comes from 32.7 kHz crystal or ring oscillator.
// - system runs on the 16 MHz ring oscillator during crystal startup.
// - with 32 MHz crystal, core, DMA and peripheral bus run full rate.
// - in 32 MHz mode the other clock branches run at half rate; the code halves only branches 1, 2 and 18.
// - seventeen peripheral clocks are enabled and disabled by software.
// - all peripheral clocks start enabled except the public-key clock.
// - processor clock stops automatically while the system sleeps.
// - RAM clock stops when processor, SPI and radio clocks are off.
// - leaving sleep or standby issues a core-logic reset.
// - watchdog, system request and lockup also reset the core logic.
// - wake-up logic takes power-on reset; pin release ends shutdown.
// - debug logic is reset only by power-on reset, never core resets.
// - holding the reset pin powers the chip down; no debug access then.
// - after power-on reset the system starts on the 16 MHz RC clock.
// - once the crystal drives the active system, ring oscillator stops.
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH
`define CRC_OFF_XTAL 8'h08
`define CRC_OFF_OSC 8'h0c
`define CRC_OFF_CLKEN 8'h10
`define CRC_OFF_STATUS 8'h14
`define CRC_OFF_CAUSE 8'h18
`define CRC_XSEL_BIT 0
`define CRC_XTAL_RST 1'h0
`define CRC_OSC_XREQ_BIT 0
`define CRC_OSC_LFX_BIT 1
`define CRC_OSC_RST 2'h0
`define CRC_NUM_SW 17
`define CRC_NUM_GATES 19
`define CRC_CLKEN_RST 17'h0ffff
`define CRC_G_RADIO 1
`define CRC_G_SPI 8
`define CRC_G_PKA 16
`define CRC_G_CPU 17
`define CRC_G_RAM 18
`define CRC_FULL_MASK 19'h3fff9
`define CRC_CORE_RST_CYC 8
`define CRC_CNT_W 4
`endif

// >>> core/crc_pkg.sv
// types of the clock and reset control block.
// assumes crc_defs.svh for the numbers.
package crc_pkg;
    typedef enum logic [1:0]
    {
        CRC_OSC_PRE = 2'h0,
        CRC_OSC_START = 2'h1,
        CRC_OSC_ACTIVE = 2'h3
    } crc_osc_state_t;

    typedef struct packed
    {
        logic lockup;
        logic sysreq;
        logic watchdog_timer_unit;
        logic wake;
    } crc_cause_t;
endpackage

// >>> core/crc_clk_gate.sv
// glitch-free clock gate that builds its clock from a rate pulse.
// assumes en_i and tick_i come from logic on clk_i.
`timescale 1ns/1ps
module crc_clk_gate
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic en_i,
    output logic gclk_o
);
    logic gclk_q;

    // a disable only ever ends a normal high phase, so no runt pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            gclk_q <= 1'b0;
        else if (tick_i)
            gclk_q <= en_i ? ~gclk_q : 1'b0;
    end

    assign gclk_o = gclk_q;

    a_gate_holds_low: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_i && !gclk_q |=> !gclk_q)
        else $error("gated clock rose while disabled");
    a_gate_on_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        !tick_i |=> $stable(gclk_q))
        else $error("gated clock moved without a tick");
endmodule

// >>> bench/tb_clock_reset_control.sv
// self-checking bench for the clock and reset control block.
// assumes crc_top driven by a classic Wishbone master at 40 MHz.
`timescale 1ns/1ps
module tb_clock_reset_control;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic pin_rst_n = 1'b1;
    logic xtal_ready = 1'b0;
    logic sleep_i = 1'b0;
    // bit 0 wake exit, 1 watchdog, 2 system request, 3 lockup
    logic [3:0] rst_src = 4'h0;
    logic xtal_high_freq_select_o;
    logic ring_osc_en_o;
    logic crystal_osc_en_o;
    logic hs_from_crystal_o;
    logic lf_from_crystal_o;
    logic shutdown_o;
    logic wakeup_logic_reset_o;
    logic debug_reset_o;
    logic core_reset_o;
    logic [18:0] gclk_o;
    logic [18:0] act;
    logic [31:0] rd;
    int tg [19];
    int err_count = 0;
    int checks = 0;

    crc_top #(.CORE_RST_CYC(2)) i_crc_top
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .external_reset_pin_low_active_i(pin_rst_n),
        .crystal_osc_ready_i(xtal_ready),
        .sleep_i(sleep_i),
        .wake_exit_i(rst_src[0]),
        .wdg_reset_i(rst_src[1]),
        .sys_reset_req_i(rst_src[2]),
        .lockup_i(rst_src[3]),
        .xtal_high_freq_select_o(xtal_high_freq_select_o),
        .ring_osc_en_o(ring_osc_en_o),
        .crystal_osc_en_o(crystal_osc_en_o),
        .hs_from_crystal_o(hs_from_crystal_o),
        .lf_from_crystal_o(lf_from_crystal_o),
        .shutdown_o(shutdown_o),
        .wakeup_logic_reset_o(wakeup_logic_reset_o),
        .debug_reset_o(debug_reset_o),
        .core_reset_o(core_reset_o),
        .gclk_o(gclk_o)
    );

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // ack and read data are taken at the rising edge that samples ack,
    // and the request is dropped right there, never earlier
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        chk_bit(wb_ack_o, 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // data goes out exactly as given, reserved bits included
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk_reg(rd, exp);
    endtask

    task automatic wait_core(input logic v);
        int n;
        n = 0;
        while (core_reset_o !== v && n < 40)
        begin
            @(negedge clk_i);
            n++;
        end
        chk_bit(core_reset_o, v);
    endtask

    // counts gated clock edges per bit over n cycles
    task automatic measure(input int n);
        logic [18:0] prev;
        act = '0;
        foreach (tg[i])
            tg[i] = 0;
        @(negedge clk_i);
        prev = gclk_o;
        repeat (n)
        begin
            @(negedge clk_i);
            act |= gclk_o ^ prev;
            for (int i = 0; i < 19; i++)
                tg[i] += int'(gclk_o[i] ^ prev[i]);
            prev = gclk_o;
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        results();
    end

    initial
    begin
        int n;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_core(1'b0);
        chk_bit(ring_osc_en_o, 1'b1);
        chk_bit(hs_from_crystal_o, 1'b0);
        chk_bit(debug_reset_o, 1'b0);
        chk_bit(xtal_high_freq_select_o, 1'b0);
        rdchk(8'h08, 32'h0);
        rdchk(8'h10, 32'h0000ffff);
        wr(8'h40, 32'hffffffff);
        rdchk(8'h40, 32'h0);
        measure(8);
        chk_reg({13'h0, act}, 32'h0006ffff);
        wr(8'h08, 32'h1);
        rdchk(8'h08, 32'h1);
        chk_bit(xtal_high_freq_select_o, 1'b1);
        wr(8'h0c, 32'h3);
        idle(4);
        chk_bit(lf_from_crystal_o, 1'b1);
        chk_bit(crystal_osc_en_o, 1'b1);
        chk_bit(ring_osc_en_o, 1'b1);
        chk_bit(hs_from_crystal_o, 1'b0);
        rdchk(8'h14, 32'h19);
        @(posedge clk_i);
        xtal_ready <= 1'b1;
        n = 0;
        while (hs_from_crystal_o !== 1'b1 && n < 10)
        begin
            @(negedge clk_i);
            n++;
        end
        chk_bit(hs_from_crystal_o, 1'b1);
        idle(1);
        chk_bit(ring_osc_en_o, 1'b0);
        rdchk(8'h14, 32'h57);
        measure(16);
        chk_reg(tg[0], 16);
        chk_reg(tg[17], 16);
        chk_reg(tg[1], 8);
        chk_reg(tg[18], 8);
        wr(8'h08, 32'h0);
        measure(16);
        chk_reg(tg[2], 16);
        wr(8'h0c, 32'h1);
        idle(2);
        chk_bit(lf_from_crystal_o, 1'b0);
        for (int i = 0; i < 17; i++)
        begin
            wr(8'h10, 32'h1 << i);
            rdchk(8'h10, 32'h1 << i);
            measure(8);
            chk_reg({15'h0, act[16:0]}, 32'h1 << i);
        end
        // ram follows cpu, spi and radio: walk each keeping it alive
        for (int j = 0; j < 4; j++)
        begin
            wr(8'h10, j == 1 ? 32'h100 : (j == 2 ? 32'h2 : 32'h0));
            @(posedge clk_i);
            sleep_i <= (j < 3);
            idle(3);
            measure(8);
            chk_bit(act[17], j == 3);
            chk_bit(act[18], j != 0);
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h08, 32'h1);
            @(posedge clk_i);
            rst_src <= 4'h1 << k;
            @(posedge clk_i);
            rst_src <= 4'h0;
            wait_core(1'b1);
            chk_bit(debug_reset_o, 1'b0);
            chk_bit(wakeup_logic_reset_o, 1'b0);
            wait_core(1'b0);
            rdchk(8'h08, 32'h0);
            rdchk(8'h18, (32'h2 << k) - 32'h1);
        end
        wr(8'h18, 32'h5);
        rdchk(8'h18, 32'ha);
        @(posedge clk_i);
        pin_rst_n <= 1'b0;
        // two sync edges, one for power-on reset, one more for core reset
        idle(5);
        chk_bit(shutdown_o, 1'b1);
        chk_bit(debug_reset_o, 1'b1);
        chk_bit(wakeup_logic_reset_o, 1'b1);
        chk_bit(core_reset_o, 1'b1);
        @(posedge clk_i);
        pin_rst_n <= 1'b1;
        idle(4);
        chk_bit(shutdown_o, 1'b0);
        chk_bit(debug_reset_o, 1'b0);
        chk_bit(core_reset_o, 1'b1);
        wait_core(1'b0);
        rdchk(8'h18, 32'h0);
        chk_bit(ring_osc_en_o, 1'b1);
        results();
    end
endmodule
